// *** include/rsq_pkg.sv ***
package rsq_pkg;
  // output queue: characters, depth, pointer width
  localparam int OQ_DEPTH = 800;
  localparam int OQ_PW = 10;
  // error queue: entries, genuine entries kept, code width
  localparam int EQ_DEPTH = 16;
  localparam int EQ_KEEP = 15;
  localparam int EQ_PW = 4;
  localparam int EC_W = 16;
  // error codes (arbitrary values)
  localparam logic [15:0] EC_OVERFLOW = 16'h0FFF;
  localparam logic [15:0] EC_DUTY_REJ = 16'h0F01;
  localparam logic [15:0] EC_NONE = 16'h0000;
  // character queued by the completion query
  localparam logic [7:0] OPC_ONE_CHAR = 8'h31;
  // register byte offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_RESP = 8'h04;
  localparam logic [7:0] OFS_ERRPUSH = 8'h08;
  localparam logic [7:0] OFS_ERRPOP = 8'h0C;
  localparam logic [7:0] OFS_ESR = 8'h10;
  localparam logic [7:0] OFS_ESE = 8'h14;
  localparam logic [7:0] OFS_SRE = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  // status byte and event register bit positions
  localparam int STB_EAV = 3;
  localparam int STB_MAV = 4;
  localparam int STB_ESB = 5;
  localparam int STB_RQS = 6;
  localparam int ESR_OPC = 0;
  // reset values and waveform codes
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] WAVE_SINE = 2'h0;
  localparam logic [1:0] WAVE_SQUARE = 2'h1;
  // command opcodes in the command register low nibble
  typedef enum logic [3:0] {
    CMD_NOP = 4'h0, CMD_CLS = 4'h1, CMD_OPC = 4'h2, CMD_OPCQ = 4'h3,
    CMD_WAVE = 4'h4, CMD_DUTY = 4'h5, CMD_EXTC = 4'h6, CMD_OPERATE_COMMAND = 4'h7,
    CMD_STBY = 4'h8
  } rsq_cmd_t;
endpackage

// *** include/rsq_q_if.sv ***
// push / pop link between the control logic and a queue store
interface rsq_q_if #(parameter int W = 8, parameter int CW = 10);
  logic push;
  logic [W-1:0] pushData;
  logic pop;
  logic clear;
  logic [W-1:0] head;
  logic empty;
  logic full;
  logic [CW-1:0] count;
  modport ctl (output push, pushData, pop, clear,
               input head, empty, full, count);
  modport store (input push, pushData, pop, clear,
                 output head, empty, full, count);
endinterface

// *** logic/rsq_out_fifo.sv ***
// 800-character first-in first-out output store
module rsq_out_fifo
  import rsq_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  rsq_q_if.store q
);
  // character storage
  logic [7:0] mem [OQ_DEPTH];
  logic [OQ_PW-1:0] wrPtr_r;
  logic [OQ_PW-1:0] rdPtr_r;
  logic [OQ_PW-1:0] cnt_r;
  wire doPush = q.push && !q.full;
  wire doPop = q.pop && !q.empty;
  wire wrLast = (wrPtr_r == OQ_PW'(OQ_DEPTH - 1));
  wire rdLast = (rdPtr_r == OQ_PW'(OQ_DEPTH - 1));

  assign q.head = mem[rdPtr_r];
  assign q.empty = (cnt_r == '0);
  assign q.full = (cnt_r == OQ_PW'(OQ_DEPTH));
  assign q.count = cnt_r;

  // storage write, no reset needed
  always_ff @(posedge clock)
  begin
    if (doPush)
      mem[wrPtr_r] <= q.pushData;
  end

  // pointers wrap at the last slot
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (doPush)
        wrPtr_r <= wrLast ? '0 : wrPtr_r + 1'b1;
      if (doPop)
        rdPtr_r <= rdLast ? '0 : rdPtr_r + 1'b1;
      cnt_r <= cnt_r + OQ_PW'(doPush) - OQ_PW'(doPop);
    end
  end
endmodule

// *** logic/rsq_err_queue.sv ***
// 16-entry error queue keeping the first errors
module rsq_err_queue
  import rsq_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  rsq_q_if.store q
);
  logic [EC_W-1:0] mem [EQ_DEPTH];
  logic [EQ_PW-1:0] wrPtr_r;
  logic [EQ_PW-1:0] rdPtr_r;
  logic [EQ_PW:0] cnt_r;
  wire doPop = q.pop && (cnt_r != '0);
  // occupancy seen by a push after a same-cycle pop
  wire [EQ_PW:0] effCnt = cnt_r - (EQ_PW+1)'(doPop);
  wire atKeep = (effCnt == (EQ_PW+1)'(EQ_KEEP));
  wire doPush = q.push && (effCnt < (EQ_PW+1)'(EQ_DEPTH));

  assign q.head = mem[rdPtr_r];
  assign q.empty = (cnt_r == '0);
  assign q.full = (cnt_r == (EQ_PW+1)'(EQ_DEPTH));
  assign q.count = cnt_r;

  always_ff @(posedge clock)
  begin
    if (doPush)
      mem[wrPtr_r] <= atKeep ? EC_OVERFLOW : q.pushData;
  end

  // clear empties the queue; pointers wrap naturally at 16
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      cnt_r <= '0;
    end
    else if (q.clear)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      wrPtr_r <= wrPtr_r + EQ_PW'(doPush);
      rdPtr_r <= rdPtr_r + EQ_PW'(doPop);
      cnt_r <= effCnt + (EQ_PW+1)'(doPush);
    end
  end

  a_err_discard: assert property (@(posedge clock) disable iff (!rstn)
    q.push && !q.pop && !q.clear && q.full |=> q.full && $stable(wrPtr_r))
    else $error("error pushed into a full error queue was kept");
endmodule

// *** logic/rsq_status_queues.sv ***
// What this block does
// - queries append responses to 800-character queue
// - controller reads remove characters in order
// - empty output queue leaves reads unanswered
// - message flag follows output queue non-empty
// - reported errors push their code until fifteen are held
// - error pop returns and removes oldest
// - error pop on empty returns zero
// - error flag follows error queue non-empty
// - error queue emptied by reset, clear-status
// - sixteen entries, first fifteen errors kept
// - overflow entry stored, then errors discarded
// - commands processed singly in arrival order
// - duty rejected unless waveform is square
// - external connection forces standby, always accepted
// - error flag weight 8, request weight 64
// - completion query queues 1 after operations
// - completion command sets event bit 0
// - enabled completion raises service request
// - clear-status clears events, request, pending completions
module rsq_status_queues
  import rsq_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // controller read of the output queue
  input wire logic ctlRdReq,
  output logic ctlRdValid,
  output logic [7:0] ctlRdData,
  // serial poll
  input wire logic spollAck,
  output logic [7:0] statusByte,
  output logic srq,
  // device operations still running
  input wire logic opsPending,
  // output settings
  output logic operate,
  output logic [1:0] waveSel,
  output logic [7:0] dutyCycle,
  output logic [7:0] extConn,
  output logic statusChangeClear
);
  import rsq_pkg::*;

  // queue links
  rsq_q_if #(.W(8), .CW(OQ_PW)) oq();
  rsq_q_if #(.W(EC_W), .CW(EQ_PW + 1)) eq();

  // output character store
  rsq_out_fifo u_out
  (
    .clock(clock),
    .rstn(rstn),
    .q(oq)
  );

  // error code store
  rsq_err_queue u_err
  (
    .clock(clock),
    .rstn(rstn),
    .q(eq)
  );

  // bus data-phase state
  logic dpValid_r;
  logic dpWrite_r;
  logic [7:0] dpAddr_r;
  logic rdDone_r;
  logic [31:0] rdData_r;
  // event, enable and request state
  logic [7:0] esr_r;
  logic [7:0] ese_r;
  logic [7:0] sre_r;
  logic rqs_r;
  logic sumPrev_r;
  // pending completion actions
  logic opcCmdPend_r;
  logic opcQryPend_r;
  // output settings
  logic operate_r;
  logic [1:0] wave_r;
  logic [7:0] duty_r;
  logic [7:0] extConn_r;
  logic stcClr_r;
  // controller read answer
  logic ctlValid_r;
  logic [7:0] ctlData_r;

  // address-phase acceptance
  wire addrTake = hsel && htrans[1] && hready;

  // register selects in the data phase
  wire selCmd = (dpAddr_r == OFS_CMD);
  wire selResp = (dpAddr_r == OFS_RESP);
  wire selErrPush = (dpAddr_r == OFS_ERRPUSH);
  wire selErrPop = (dpAddr_r == OFS_ERRPOP);
  wire selEsr = (dpAddr_r == OFS_ESR);
  wire selEse = (dpAddr_r == OFS_ESE);
  wire selSre = (dpAddr_r == OFS_SRE);

  wire cmdBlock = (selCmd || selResp) && opcQryPend_r;
  wire respBlock = selResp && oq.full;
  wire wrStall = dpValid_r && dpWrite_r && (cmdBlock || respBlock);
  wire rdStall = dpValid_r && !dpWrite_r && !rdDone_r;

  assign hreadyout = !(wrStall || rdStall);
  assign hresp = 1'b0;
  assign hrdata = rdData_r;

  // write completes on the edge where the slave is ready
  wire wrFire = dpValid_r && dpWrite_r && !wrStall;
  // read captures (with side effects) in its first data cycle
  wire rdCap = dpValid_r && !dpWrite_r && !rdDone_r;

  // command decode from the written word
  wire [3:0] cmdOp = hwdata[3:0];
  wire [7:0] cmdArg = hwdata[15:8];
  wire cmdFire = wrFire && selCmd;
  wire clsCmd = cmdFire && (cmdOp == CMD_CLS);
  wire opcCmd = cmdFire && (cmdOp == CMD_OPC);
  wire opcqCmd = cmdFire && (cmdOp == CMD_OPCQ);
  wire waveCmd = cmdFire && (cmdOp == CMD_WAVE);
  wire dutyCmd = cmdFire && (cmdOp == CMD_DUTY);
  wire extCmd = cmdFire && (cmdOp == CMD_EXTC);
  wire operCmd = cmdFire && (cmdOp == CMD_OPERATE_COMMAND);
  wire stbyCmd = cmdFire && (cmdOp == CMD_STBY);
  wire dutyOk = (wave_r == WAVE_SQUARE);
  wire dutyReject = dutyCmd && !dutyOk;

  // completion once no operation is running
  wire opcCmdDone = opcCmdPend_r && !opsPending && !clsCmd;
  // queue the 1 after operations settle
  wire opcQryDone = opcQryPend_r && !opsPending && !oq.full && !clsCmd;

  assign oq.push = (wrFire && selResp) || opcQryDone;
  assign oq.pushData = opcQryDone ? OPC_ONE_CHAR : hwdata[7:0];
  assign oq.clear = 1'b0;

  wire ctlPop = ctlRdReq && !oq.empty && !ctlValid_r;
  assign oq.pop = ctlPop;

  // reported and rejected errors enter queue
  assign eq.push = (wrFire && selErrPush) || dutyReject;
  assign eq.pushData = dutyReject ? EC_DUTY_REJ : hwdata[EC_W-1:0];
  assign eq.pop = rdCap && selErrPop;
  assign eq.clear = clsCmd;

  // event summary and request summary
  wire esb = |(esr_r & ese_r);
  wire [7:0] stbLow = {1'b0, 1'b0, esb, !oq.empty, !eq.empty, 3'b000};
  wire summary = |(stbLow & sre_r);
  wire sumRise = summary && !sumPrev_r;

  assign statusByte = {1'b0, rqs_r, stbLow[5:0]};
  assign srq = rqs_r;

  // empty queue reads as zero code
  wire [15:0] errRead = eq.empty ? EC_NONE : eq.head;

  // read value multiplexer
  wire [31:0] rdMux =
    selErrPop ? {16'h0000, errRead} :
    selEsr ? {24'h000000, esr_r} :
    selEse ? {24'h000000, ese_r} :
    selSre ? {24'h000000, sre_r} :
    (dpAddr_r == OFS_STATUS) ?
      {6'h00, oq.count, 4'h0, operate_r, wave_r, 1'b0, statusByte} :
    32'h00000000;

  // address phase captured, data phase held while stalled
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      dpValid_r <= 1'b0;
      dpWrite_r <= 1'b0;
      dpAddr_r <= RST_BYTE;
    end
    else if (hready)
    begin
      dpValid_r <= addrTake;
      dpWrite_r <= hwrite;
      dpAddr_r <= haddr[7:0];
    end
  end

  // read data registered one cycle into the data phase
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rdDone_r <= 1'b0;
      rdData_r <= 32'h00000000;
    end
    else
    begin
      rdDone_r <= rdCap;
      if (rdCap)
        rdData_r <= rdMux;
    end
  end

  // event status: completion sets, read or clear-status clears
  logic [7:0] esr_nxt;
  always_comb
  begin
    esr_nxt = esr_r;
    if (clsCmd || (rdCap && selEsr))
      esr_nxt = RST_BYTE;
    // completion sets bit 0, set wins
    if (opcCmdDone)
      esr_nxt[ESR_OPC] = 1'b1;
  end

  // enable masks and event register
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      esr_r <= RST_BYTE;
      ese_r <= RST_BYTE;
      sre_r <= RST_BYTE;
    end
    else
    begin
      esr_r <= esr_nxt;
      if (wrFire && selEse)
        ese_r <= hwdata[7:0];
      if (wrFire && selSre)
        sre_r <= hwdata[7:0];
    end
  end

  // request latch: rising summary sets, poll or clear-status clears
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rqs_r <= 1'b0;
      sumPrev_r <= 1'b0;
    end
    else
    begin
      sumPrev_r <= summary;
      // request bit cleared, new rise wins
      if (sumRise)
        rqs_r <= 1'b1;
      else if (clsCmd || spollAck)
        rqs_r <= 1'b0;
    end
  end

  // pending completion actions
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      opcCmdPend_r <= 1'b0;
      opcQryPend_r <= 1'b0;
    end
    else
    begin
      if (clsCmd || opcCmdDone)
        opcCmdPend_r <= 1'b0;
      else if (opcCmd)
        opcCmdPend_r <= 1'b1;
      if (clsCmd || opcQryDone)
        opcQryPend_r <= 1'b0;
      else if (opcqCmd)
        opcQryPend_r <= 1'b1;
    end
  end

  // output settings driven by commands
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      operate_r <= 1'b0;
      wave_r <= WAVE_SINE;
      duty_r <= RST_BYTE;
      extConn_r <= RST_BYTE;
      stcClr_r <= 1'b0;
    end
    else
    begin
      stcClr_r <= clsCmd;
      if (extCmd || stbyCmd)
        operate_r <= 1'b0;
      else if (operCmd)
        operate_r <= 1'b1;
      if (extCmd)
        extConn_r <= cmdArg;
      if (waveCmd)
        wave_r <= cmdArg[1:0];
      if (dutyCmd && dutyOk)
        duty_r <= cmdArg;
    end
  end

  // controller read answer, one-cycle valid
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      ctlValid_r <= 1'b0;
      ctlData_r <= RST_BYTE;
    end
    else
    begin
      ctlValid_r <= ctlPop;
      if (ctlPop)
        ctlData_r <= oq.head;
    end
  end

  assign ctlRdValid = ctlValid_r;
  assign ctlRdData = ctlData_r;
  assign operate = operate_r;
  assign waveSel = wave_r;
  assign dutyCycle = duty_r;
  assign extConn = extConn_r;
  assign statusChangeClear = stcClr_r;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  a_oq_fill: assert property (oq.push && !oq.full |=> !oq.empty)
    else $error("output queue push lost");
  a_read_order: assert property (ctlPop |=> ctlRdData == $past(oq.head))
    else $error("controller read not oldest char");
  a_empty_silent: assert property (oq.empty |=> !ctlRdValid)
    else $error("empty queue answered a read");
  a_mav_flag: assert property (oq.push && oq.empty && !oq.full
    |=> statusByte[STB_MAV])
    else $error("message flag missed a push");
  a_err_push: assert property (dutyReject |-> eq.push && !eq.clear)
    else $error("rejected duty not logged");
  a_err_zero: assert property (rdCap && selErrPop && eq.empty
    |=> hrdata == 32'h00000000)
    else $error("empty error pop not zero");
  a_eav_flag: assert property (eq.push && !eq.clear |=> statusByte[3])
    else $error("error flag not raised");
  a_cls_empty: assert property (clsCmd |=> eq.empty && esr_r == 8'h00)
    else $error("clear-status left state");
  a_cmd_serial: assert property (opcQryPend_r && dpValid_r && dpWrite_r
    && selCmd |-> !hreadyout)
    else $error("command taken during completion query");
  a_duty_keep: assert property (dutyReject |=> $stable(dutyCycle))
    else $error("non-square duty accepted");
  a_ext_stby: assert property (extCmd |=> !operate)
    else $error("external setting left operate");
  a_opcq_wait: assert property (opcQryPend_r && opsPending |-> !oq.push)
    else $error("completion reply before operations done");
  a_opc_bit: assert property (opcCmdDone |=> esr_r[0])
    else $error("completion bit not set");
  a_srq_rise: assert property (sumRise |=> srq)
    else $error("service request not raised");
  a_cls_cancel: assert property (clsCmd |=> !opcQryPend_r && !opcCmdPend_r
    ##1 !statusByte[6] || $past(sumRise))
    else $error("clear-status left pending completion");
  a_full_stall: assert property (dpValid_r && dpWrite_r && selResp
    && oq.full |-> !hreadyout)
    else $error("response taken into full queue");
  a_flag_same: assert property (ctlPop && oq.count == 10'h001 && !oq.push
    |=> !statusByte[STB_MAV])
    else $error("message flag late on last read");
endmodule

// *** verif/rsq_ctl_model.sv ***
// remote controller: reads the output queue one character at a time
module rsq_ctl_model
  import rsq_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic readEn,
  input wire logic slow,
  input wire logic ctlRdValid,
  input wire logic [7:0] ctlRdData,
  output logic ctlRdReq
);
  timeunit 1ns;
  timeprecision 1ps;
  // characters received, oldest first
  logic [7:0] got[$];
  // idle cycles left before asking again
  int gapCnt;
  // read follows query
  // request held until answered; a slow controller pauses after each
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      ctlRdReq <= 1'b0;
      gapCnt <= 0;
    end
    else if (ctlRdValid === 1'b1)
    begin
      got.push_back(ctlRdData);
      ctlRdReq <= readEn && !slow;
      gapCnt <= slow ? 3 : 0;
    end
    else if (gapCnt > 0)
      gapCnt <= gapCnt - 1;
    else
      ctlRdReq <= readEn;
  end
endmodule

// *** verif/tb_top.sv ***
// self-checking bench for the status and queue block
module tb_top
  import rsq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  // bus master side, idle at time zero
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h00000000;
  logic hreadyout, hresp, ctlRdValid, ctlRdReq, srq, operate, scc;
  logic [31:0] hrdata;
  logic [7:0] ctlRdData, statusByte, dutyCycle, extConn;
  logic [1:0] waveSel;
  logic spollAck = 1'b0;
  logic opsPending = 1'b0;
  logic readEn = 1'b0;
  logic slow = 1'b0;
  int nErrors = 0;
  int checked = 0;
  // clear-status pulses seen
  int nScc = 0;

  rsq_status_queues dut (.clock(clock), .rstn(rstn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .ctlRdReq(ctlRdReq),
    .ctlRdValid(ctlRdValid), .ctlRdData(ctlRdData), .spollAck(spollAck),
    .statusByte(statusByte), .srq(srq), .opsPending(opsPending),
    .operate(operate), .waveSel(waveSel), .dutyCycle(dutyCycle),
    .extConn(extConn), .statusChangeClear(scc));
  rsq_ctl_model mdl (.clock(clock), .rstn(rstn), .readEn(readEn),
    .slow(slow), .ctlRdValid(ctlRdValid), .ctlRdData(ctlRdData),
    .ctlRdReq(ctlRdReq));

  // half-period toggle gives 5 ns
  always #2.5 clock = ~clock;
  // count clear-status pulses
  always @(posedge clock)
    if (scc === 1'b1)
      nScc++;

  task automatic print_verdict();
    if (nErrors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic fail(input string m);
    nErrors++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask

  task automatic check_word(input logic [31:0] g, e, input string m);
    checked++;
    if (g !== e)
      fail($sformatf("%s got %h exp %h", m, g, e));
  endtask

  task automatic check_byte(input logic [7:0] g, e, input string m);
    check_word({24'h000000, g}, {24'h000000, e}, m);
  endtask

  task automatic check_bit(input logic g, e, input string m);
    check_word({31'h00000000, g}, {31'h00000000, e}, m);
  endtask

  // sample settled outputs away from the rising edge
  task automatic look();
    @(negedge clock);
  endtask

  // wait for hready sampled high at a rising edge, bounded
  task automatic wait_ready();
    int n;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 4000);
    if (n >= 4000)
    begin
      fail("bus wait timed out");
      print_verdict();
    end
  endtask

  // one single-word transfer: address phase, then data phase
  task automatic ahb(input logic wr, input logic [7:0] ofs,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= {24'h000000, ofs};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? wd : 32'h00000000;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic cmd(input rsq_cmd_t op, input logic [7:0] arg);
    logic [31:0] d;
    ahb(1'b1, OFS_CMD, {16'h0000, arg, 4'h0, op}, d);
  endtask

  // wait until the controller holds n characters, bounded
  task automatic wait_chars(input int n);
    int k;
    for (k = 0; k < 20000 && mdl.got.size() < n; k++)
      @(posedge clock);
    if (mdl.got.size() < n)
    begin
      fail("controller read timed out");
      print_verdict();
    end
  endtask

  task automatic t_reset();
    look();
    check_byte(statusByte, 8'h00, "status after reset");
    check_bit(srq, 1'b0, "request after reset");
  endtask

  task automatic t_outq();
    logic [31:0] d;
    mdl.got.delete();
    for (int i = 0; i < 3; i++)
      ahb(1'b1, OFS_RESP, 32'h00000041 + i, d);
    look();
    check_byte(statusByte, 8'h10, "message flag set");
    @(posedge clock);
    readEn <= 1'b1;
    slow <= 1'b1;
    wait_chars(3);
    for (int i = 0; i < 3; i++)
      check_byte(mdl.got[i], 8'(8'h41 + i), "queue order");
    look();
    check_byte(statusByte, 8'h00, "message flag clear");
    repeat (20) @(posedge clock);
    check_word(mdl.got.size(), 32'h3, "empty read answered");
    readEn <= 1'b0;
    slow <= 1'b0;
  endtask

  task automatic t_errq();
    logic [31:0] d;
    ahb(1'b0, OFS_ERRPOP, 32'h0, d);
    check_word(d, {16'h0000, EC_NONE}, "pop empty");
    for (int i = 1; i <= 17; i++)
      ahb(1'b1, OFS_ERRPUSH, i, d);
    look();
    check_byte(statusByte & 8'h08, 8'h08, "error flag");
    for (int i = 1; i <= 15; i++)
    begin
      ahb(1'b0, OFS_ERRPOP, 32'h0, d);
      check_word(d, i, "kept error");
    end
    ahb(1'b0, OFS_ERRPOP, 32'h0, d);
    check_word(d, {16'h0000, EC_OVERFLOW}, "overflow entry");
    ahb(1'b0, OFS_ERRPOP, 32'h0, d);
    check_word(d, {16'h0000, EC_NONE}, "later errors dropped");
    look();
    check_byte(statusByte, 8'h00, "error flag clear");
  endtask

  task automatic t_event();
    logic [31:0] d;
    int s;
    ahb(1'b1, OFS_ERRPUSH, 32'h00000005, d);
    ahb(1'b1, OFS_ESE, 32'h00000001, d);
    ahb(1'b1, OFS_SRE, 32'h00000020, d);
    ahb(1'b0, OFS_ESE, 32'h0, d);
    check_word(d, 32'h00000001, "event mask readback");
    @(posedge clock);
    opsPending <= 1'b1;
    cmd(CMD_OPC, 8'h00);
    repeat (10) @(posedge clock);
    look();
    check_bit(srq, 1'b0, "no request while busy");
    @(posedge clock);
    opsPending <= 1'b0;
    repeat (5) @(posedge clock);
    look();
    check_byte(statusByte, 8'h68, "completion requests");
    ahb(1'b0, OFS_ESR, 32'h0, d);
    check_word(d, 32'h00000001, "completion bit 0");
    @(posedge clock);
    spollAck <= 1'b1;
    @(posedge clock);
    spollAck <= 1'b0;
    look();
    check_bit(srq, 1'b0, "poll clears request");
    cmd(CMD_OPC, 8'h00);
    repeat (3) @(posedge clock);
    @(posedge clock);
    opsPending <= 1'b1;
    cmd(CMD_OPC, 8'h00);
    s = nScc;
    cmd(CMD_CLS, 8'h00);
    @(posedge clock);
    opsPending <= 1'b0;
    repeat (5) @(posedge clock);
    look();
    check_byte(statusByte, 8'h00, "clear status");
    check_word(nScc - s, 32'h1, "change clear pulse");
    ahb(1'b0, OFS_ESR, 32'h0, d);
    check_word(d, 32'h0, "pending completion cancelled");
    ahb(1'b0, OFS_ERRPOP, 32'h0, d);
    check_word(d, {16'h0000, EC_NONE}, "error queue cleared");
  endtask

  task automatic t_query();
    mdl.got.delete();
    @(posedge clock);
    opsPending <= 1'b1;
    readEn <= 1'b1;
    cmd(CMD_OPCQ, 8'h00);
    repeat (10) @(posedge clock);
    check_word(mdl.got.size(), 32'h0, "answer while busy");
    opsPending <= 1'b0;
    wait_chars(1);
    check_byte(mdl.got[0], OPC_ONE_CHAR, "completion char");
    readEn <= 1'b0;
  endtask

  task automatic t_settings();
    logic [31:0] d;
    cmd(CMD_WAVE, {6'h00, WAVE_SINE});
    cmd(CMD_DUTY, 8'h40);
    look();
    check_byte(dutyCycle, 8'h00, "duty refused");
    ahb(1'b0, OFS_ERRPOP, 32'h0, d);
    check_word(d, {16'h0000, EC_DUTY_REJ}, "duty error");
    cmd(CMD_WAVE, {6'h00, WAVE_SQUARE});
    cmd(CMD_DUTY, 8'h40);
    cmd(CMD_OPERATE_COMMAND, 8'h00);
    look();
    check_byte(dutyCycle, 8'h40, "duty taken");
    check_bit(operate, 1'b1, "operate");
    check_byte({6'h00, waveSel}, {6'h00, WAVE_SQUARE}, "wave pins");
    check_bit(hresp, 1'b0, "bus response okay");
    cmd(CMD_EXTC, 8'h05);
    ahb(1'b0, OFS_STATUS, 32'h0, d);
    check_word(d & 32'h00000E00, 32'h00000200, "standby forced");
    check_byte(extConn, 8'h05, "connection kept");
    ahb(1'b1, 8'h20, 32'h000000FF, d);
    ahb(1'b0, 8'h20, 32'h0, d);
    check_word(d, 32'h0, "unmapped read");
  endtask

  task automatic t_full();
    logic [31:0] d;
    mdl.got.delete();
    for (int i = 0; i < OQ_DEPTH; i++)
      ahb(1'b1, OFS_RESP, i & 32'hFF, d);
    ahb(1'b0, OFS_STATUS, 32'h0, d);
    check_word(d & 32'h03FF0000, 32'h03200000, "800 held");
    fork
      ahb(1'b1, OFS_RESP, 32'h000000AA, d);
      begin
        repeat (20) @(negedge clock);
        check_bit(hreadyout, 1'b0, "full queue stalls");
        @(posedge clock);
        readEn <= 1'b1;
      end
    join
    wait_chars(OQ_DEPTH + 1);
    for (int i = 0; i < OQ_DEPTH; i++)
      check_byte(mdl.got[i], i[7:0], "drain order");
    check_byte(mdl.got[OQ_DEPTH], 8'hAA, "stalled char");
    readEn <= 1'b0;
  endtask

  // reset for 8 cycles, then each scenario in turn
  initial
  begin
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    t_reset();
    t_outq();
    t_errq();
    t_event();
    t_query();
    t_settings();
    t_full();
    print_verdict();
  end
endmodule
